// ==== fwi_ctrl.sv ====
// Purpose: shared interrupt controller with vector byte substitution
// Assumes: sources are one-cycle pulses on the core clock; APB, zero wait
// Notes: source order 0..13 equals priority 1..14
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps

module fwi_ctrl (
  input wire logic MCLK_IN,
  input wire logic RESET_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [13:0] SRC_EVENT_IN,
  input wire logic [15:0] FETCH_ADDR_IN,
  input wire logic [7:0] FETCH_DATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  output logic [7:0] FETCH_DATA_OUT,
  output logic SHARED_BUFFER_WAVEFORM_INTERRUPT_OUT
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [13:0] source_enable_bit;
  logic [13:0] request_latch;
  logic autovector_enable;
  logic main_flag;
  logic [7:0] source_vector_byte_reg;
  logic [13:0] pending;
  logic any_pending;
  logic [7:0] next_vector;
  logic wr_acc;
  logic rd_acc;
  logic main_clr;
  logic [13:0] latch_clr;
  logic addr_ok;

  // Priority encoder: lowest index is highest priority
  function automatic logic [7:0] vec_of(input logic [13:0] p);
    logic [7:0] v;
    v = fwi_pkg::VEC_RST;
    for (int i = fwi_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (p[i]) begin
        v = fwi_pkg::VEC_BASE + 8'(i) * fwi_pkg::VEC_STEP;
      end
    end
    return v;
  endfunction

  assign wr_acc = PSEL_IN && PENABLE_IN && PWRITE_IN;
  assign rd_acc = PSEL_IN && PENABLE_IN && !PWRITE_IN;
  assign pending = request_latch & source_enable_bit;
  // Enabled sources still pending once this cycle's write-1-clear has landed
  assign any_pending = |(pending & ~latch_clr);
  assign next_vector = vec_of(pending);
  assign main_clr = wr_acc && (PADDR_IN == fwi_pkg::OFS_EXTFLAG) && !PWDATA_IN[fwi_pkg::EXTFLAG_MAIN_BIT];
  assign latch_clr = (wr_acc && PADDR_IN == fwi_pkg::OFS_REQUEST) ? PWDATA_IN[13:0] : 14'h0000;
  assign addr_ok = (PADDR_IN == fwi_pkg::OFS_ENABLE) || (PADDR_IN == fwi_pkg::OFS_REQUEST) ||
                   (PADDR_IN == fwi_pkg::OFS_VECTOR) || (PADDR_IN == fwi_pkg::OFS_SETUP) ||
                   (PADDR_IN == fwi_pkg::OFS_EXTFLAG);

  // ----------------------------------------
  // Request latches; a new event beats a clear
  // ----------------------------------------
  generate
    for (genvar g = 0; g < fwi_pkg::NUM_SRC; g++) begin : g_latch
      always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
          request_latch[g] <= 1'b0;
        end else if (SRC_EVENT_IN[g]) begin
          request_latch[g] <= 1'b1;
        end else if (latch_clr[g]) begin
          request_latch[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Configuration
  // ----------------------------------------
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      source_enable_bit <= fwi_pkg::ENABLE_RST;
      autovector_enable <= 1'b0;
    end else if (wr_acc) begin
      if (PADDR_IN == fwi_pkg::OFS_ENABLE) begin
        source_enable_bit <= PWDATA_IN[13:0];
      end
      if (PADDR_IN == fwi_pkg::OFS_SETUP) begin
        autovector_enable <= PWDATA_IN[fwi_pkg::SETUP_AV_BIT];
      end
    end
  end

  // ----------------------------------------
  // Main flag: a newly pending source, or a latch clear that leaves another
  // source pending, sets it; set wins over the clear. While the flag is
  // held set a re-raise is absorbed, so software clears it first.
  // ----------------------------------------
  logic [13:0] pending_q;
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      pending_q <= 14'h0000;
      main_flag <= 1'b0;
    end else begin
      pending_q <= pending;
      if ((|(pending & ~pending_q)) || (latch_clr != 14'h0000 && any_pending)) begin
        main_flag <= 1'b1;
      end else if (main_clr) begin
        main_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      source_vector_byte_reg <= fwi_pkg::VEC_RST;
    end else begin
      source_vector_byte_reg <= next_vector;
    end
  end

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      SHARED_BUFFER_WAVEFORM_INTERRUPT_OUT <= 1'b0;
    end else begin
      SHARED_BUFFER_WAVEFORM_INTERRUPT_OUT <= main_flag;
    end
  end

  // ----------------------------------------
  // Jump fetch splice: registered, one cycle from fetch address to data.
  // The core's vector jump to the fixed address and its eight-cycle entry
  // path are its own; only the low target byte is touched here.
  // ----------------------------------------
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      FETCH_DATA_OUT <= 8'h00;
    end else if (autovector_enable && FETCH_ADDR_IN == fwi_pkg::JUMP_LO_ADDR) begin
      FETCH_DATA_OUT <= source_vector_byte_reg;
    end else begin
      FETCH_DATA_OUT <= FETCH_DATA_IN;
    end
  end

  // ----------------------------------------
  // APB: zero wait states, error on unmapped offsets
  // ----------------------------------------
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      PRDATA_OUT <= 32'h00000000;
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
    end else begin
      PREADY_OUT <= PSEL_IN && !PENABLE_IN;
      PSLVERR_OUT <= PSEL_IN && !PENABLE_IN && !addr_ok;
      PRDATA_OUT <= 32'h00000000;
      if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
        unique case (PADDR_IN)
          fwi_pkg::OFS_ENABLE: PRDATA_OUT <= {18'h00000, source_enable_bit};
          fwi_pkg::OFS_REQUEST: PRDATA_OUT <= {18'h00000, request_latch};
          fwi_pkg::OFS_VECTOR: PRDATA_OUT <= {24'h000000, source_vector_byte_reg};
          fwi_pkg::OFS_SETUP: PRDATA_OUT <= {31'h00000000, autovector_enable};
          fwi_pkg::OFS_EXTFLAG: PRDATA_OUT <= {25'h0000000, main_flag, 6'h00};
          default: PRDATA_OUT <= 32'h00000000;
        endcase
      end
    end
  end

  logic unused_rd;
  assign unused_rd = rd_acc;

endmodule

// ==== fwi_pkg.sv ====
// Purpose: constants for the shared buffer/waveform interrupt controller
// Assumes: APB slave, 32-bit data, byte addresses
// Notes: vector byte spliced into the jump fetch at the fixed location

package fwi_pkg;
  localparam int NUM_SRC = 14;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [11:0] OFS_ENABLE = 12'h000;
  localparam logic [11:0] OFS_REQUEST = 12'h004;
  localparam logic [11:0] OFS_VECTOR = 12'h008;
  localparam logic [11:0] OFS_SETUP = 12'h00C;
  localparam logic [11:0] OFS_EXTFLAG = 12'h010;
  // ----------------------------------------
  // Fields and values
  // ----------------------------------------
  localparam int SETUP_AV_BIT = 0;
  localparam int EXTFLAG_MAIN_BIT = 6;
  localparam logic [7:0] VEC_BASE = 8'h80;
  localparam logic [7:0] VEC_STEP = 8'h04;
  localparam logic [15:0] JUMP_VEC_ADDR = 16'h0053;
  localparam logic [15:0] JUMP_HI_ADDR = 16'h0054;
  localparam logic [15:0] JUMP_LO_ADDR = 16'h0055;
  localparam logic [13:0] ENABLE_RST = 14'h0000;
  localparam logic [7:0] VEC_RST = 8'h80;
  localparam int AUTOVEC_INSTR_CYCLES = 8;
endpackage

// ==== fwi_core_mdl.sv ====
// Purpose: core-side program memory bytes around the shared vector
// Assumes: fetch byte appears combinationally for the fetch address
// Notes: page value is arbitrary
`timescale 1ns/1ps
module fwi_core_mdl #(parameter logic [7:0] PAGE = 8'h04) (
  input wire logic [15:0] addr_in,
  output logic [7:0] data_out
);
  always_comb begin
    case (addr_in)
      16'h0053: data_out = 8'h02; // Long jump opcode at the fixed vector
      16'h0054: data_out = PAGE; // Table page
      16'h0055: data_out = 8'h80; // Table at page plus 0x80
      default: data_out = ~addr_in[7:0];
    endcase
  end
endmodule

// ==== fwi_ctrl_props.sv ====
// Purpose: port checks for the shared interrupt controller
// Assumes: zero-wait bus, request output two or three edges after its cause
// Notes: bound to every controller instance
`timescale 1ns/1ps
module fwi_ctrl_props (
  input wire logic MCLK_IN, RESET_N_IN, PSEL_IN, PENABLE_IN, PWRITE_IN, PREADY_OUT, PSLVERR_OUT,
  input wire logic SHARED_BUFFER_WAVEFORM_INTERRUPT_OUT,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN, PRDATA_OUT,
  input wire logic [13:0] SRC_EVENT_IN,
  input wire logic [15:0] FETCH_ADDR_IN,
  input wire logic [7:0] FETCH_DATA_IN, FETCH_DATA_OUT
);
  wire logic irq = SHARED_BUFFER_WAVEFORM_INTERRUPT_OUT;
  wire logic wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
  wire logic clr = wr && PADDR_IN == fwi_pkg::OFS_EXTFLAG && !PWDATA_IN[6];
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  sequence setup_s; PSEL_IN && !PENABLE_IN; endsequence
  sequence answer_s; PREADY_OUT ##1 !PREADY_OUT; endsequence
  bus_answer_a: assert property (setup_s |=> answer_s) else $error("no single ready pulse");
  ready_cause_a: assert property ($rose(PREADY_OUT) |-> $past(PSEL_IN && !PENABLE_IN)) else $error("stray ready");
  unmapped_a: assert property (setup_s ##0 PADDR_IN > fwi_pkg::OFS_EXTFLAG |=> PSLVERR_OUT && PRDATA_OUT == 32'h0)
    else $error("unmapped not refused");
  vec_form_a: assert property (PREADY_OUT && !PWRITE_IN && PADDR_IN == fwi_pkg::OFS_VECTOR |->
    PRDATA_OUT[1:0] == 2'h0 && PRDATA_OUT inside {[32'h80:32'hB4]}) else $error("bad vector");
  fetch_pass_a: assert property (FETCH_ADDR_IN != fwi_pkg::JUMP_LO_ADDR |=> FETCH_DATA_OUT == $past(FETCH_DATA_IN))
    else $error("fetch byte altered");
  irq_rise_a: assert property ($rose(irq) |-> $past(|SRC_EVENT_IN, 3) || $past(wr, 2) || $past(wr, 3))
    else $error("request without cause");
  irq_fall_a: assert property ($fell(irq) |-> $past(clr, 2)) else $error("request dropped");
  irq_hold_a: assert property (irq && !clr && !$past(clr) |=> irq) else $error("request not held");
endmodule
bind fwi_ctrl fwi_ctrl_props chk (.*);

// ==== fwi_ctrl_tb_top.sv ====
// Purpose: self-checking bench for the shared interrupt controller
// Assumes: zero-wait bus, core model supplies fetch bytes
// Notes: per-source rows first, then ordering and refusal cases
`timescale 1ns/1ps
module fwi_ctrl_tb_top;
  logic MCLK_IN = 0, RESET_N_IN = 0, PSEL_IN = 0, PENABLE_IN = 0, PWRITE_IN = 0;
  logic PREADY_OUT, PSLVERR_OUT, SHARED_BUFFER_WAVEFORM_INTERRUPT_OUT, er;
  logic [11:0] PADDR_IN = 12'h000;
  logic [31:0] PWDATA_IN = 32'h0, PRDATA_OUT, rd;
  logic [13:0] SRC_EVENT_IN = 14'h0;
  logic [15:0] FETCH_ADDR_IN = 16'h0;
  logic [7:0] FETCH_DATA_IN, FETCH_DATA_OUT;
  int err_total = 0, cmp_count = 0;
  typedef struct {logic [13:0] ev; logic [7:0] vec;} fwi_row_t;
  fwi_row_t rows [17];
  wire logic irq = SHARED_BUFFER_WAVEFORM_INTERRUPT_OUT;
  localparam logic [11:0] EN = fwi_pkg::OFS_ENABLE, RQ = fwi_pkg::OFS_REQUEST, VEC = fwi_pkg::OFS_VECTOR;
  localparam logic [11:0] SU = fwi_pkg::OFS_SETUP, EX = fwi_pkg::OFS_EXTFLAG;
  always #2 MCLK_IN = ~MCLK_IN;
  fwi_ctrl dut (.*);
  fwi_core_mdl core (.addr_in(FETCH_ADDR_IN), .data_out(FETCH_DATA_IN));
  task automatic chk(input logic [31:0] e, input logic [31:0] a);
    cmp_count++;
    if (a !== e) begin
      err_total++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge MCLK_IN);
    PSEL_IN <= 1'h1;
    PWRITE_IN <= w;
    PADDR_IN <= a;
    PWDATA_IN <= d;
    @(posedge MCLK_IN);
    PENABLE_IN <= 1'h1;
    do @(posedge MCLK_IN); while (PREADY_OUT !== 1'h1);
    rd = PRDATA_OUT;
    er = PSLVERR_OUT;
    PSEL_IN <= 1'h0;
    PENABLE_IN <= 1'h0;
  endtask
  task automatic pulse(input logic [13:0] v);
    @(posedge MCLK_IN);
    SRC_EVENT_IN <= v;
    @(posedge MCLK_IN);
    SRC_EVENT_IN <= 14'h0;
    repeat (4) @(posedge MCLK_IN);
  endtask
  task automatic fetch(input logic [7:0] e);
    @(posedge MCLK_IN);
    FETCH_ADDR_IN <= fwi_pkg::JUMP_LO_ADDR;
    repeat (2) @(posedge MCLK_IN);
    chk(32'(e), 32'(FETCH_DATA_OUT));
  endtask
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    finish_test;
  end
  initial begin
    for (int i = 0; i < 14; i++) rows[i] = '{14'h1 << i, 8'h80 + 8'(4 * i)};
    rows[14] = '{14'h0300, 8'hA0};
    rows[15] = '{14'h3010, 8'h90};
    rows[16] = '{14'h2001, 8'h80};
    repeat (20) @(posedge MCLK_IN);
    RESET_N_IN <= 1'h1;
    apb(0, VEC, 32'h0);
    chk(32'h80, rd);
    apb(1, EN, 32'h3FFF);
    apb(1, SU, 32'h1);
    foreach (rows[i]) begin
      pulse(rows[i].ev);
      chk(32'h1, 32'(irq));
      apb(0, VEC, 32'h0);
      chk(32'(rows[i].vec), rd);
      fetch(rows[i].vec);
      apb(1, EX, 32'h0);
      apb(1, RQ, 32'(rows[i].ev));
      apb(0, RQ, 32'h0);
      chk(32'h0, rd);
      chk(32'h0, 32'(irq));
      $display("row %0d done", i);
    end
    // Main cleared first, then the top latch: the lower source must re-raise
    pulse(14'h0011);
    apb(1, EX, 32'h0);
    apb(1, RQ, 32'h1);
    repeat (4) @(posedge MCLK_IN);
    chk(32'h1, 32'(irq));
    apb(0, VEC, 32'h0);
    chk(32'h90, rd);
    apb(1, EX, 32'h40);
    chk(32'h1, 32'(irq));
    apb(1, RQ, 32'h10);
    apb(1, EX, 32'h0);
    $display("reassert case done");
    apb(1, EN, 32'h1FFF);
    pulse(14'h2000);
    chk(32'h0, 32'(irq));
    apb(0, RQ, 32'h0);
    chk(32'h2000, rd);
    apb(1, EN, 32'h3FFF);
    apb(1, SU, 32'h0);
    fetch(8'h80);
    apb(1, RQ, 32'h2000);
    apb(1, EX, 32'h0);
    apb(0, 12'h014, 32'h0);
    chk(32'h1, 32'(er));
    chk(32'h0, rd);
    $display("disable and refusal cases done");
    finish_test;
  end
endmodule
